// ---- rtl/mpc_pkg.sv ----
package mpc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_VECTOR     = 4'h2;
  localparam logic [3:0] ADDR_RX_CTRL    = 4'h3;
  localparam logic [3:0] ADDR_FRAME_CTRL = 4'h4;
  localparam logic [3:0] ADDR_TX_CTRL    = 4'h5;
  localparam logic [3:0] ADDR_SYNC_LOW   = 4'h6;
  localparam logic [3:0] ADDR_SYNC_HIGH  = 4'h7;
  localparam logic [3:0] ADDR_STATUS     = 4'h8;
  localparam logic [3:0] ADDR_EVENT      = 4'h9;
  localparam logic [3:0] ADDR_CMD        = 4'ha;

  // receive_control fields
  localparam int RC_ENABLE  = 0;
  localparam int RC_SYNC_INH = 1;
  localparam int RC_ADDR_SRCH = 2;
  localparam int RC_CRC_EN  = 3;
  localparam int RC_HUNT    = 4;
  localparam int RC_AUTO    = 5;
  localparam int RC_LEN_LO  = 6;

  // framing_control fields
  localparam int FC_PAR_EN  = 0;
  localparam int FC_PAR_EVEN = 1;
  localparam int FC_STOP_LO = 2;
  localparam int FC_SYNC_LO = 4;
  localparam int FC_CLK_LO  = 6;

  // transmit_control fields
  localparam int TC_RTS     = 1;
  localparam int TC_CRC16   = 2;
  localparam int TC_TX_EN   = 3;
  localparam int TC_BREAK   = 4;
  localparam int TC_LEN_LO  = 5;

  // primary_status fields
  localparam int ST_CHAR_AVAIL = 0;
  localparam int ST_IN_SERVICE = 1;
  localparam int ST_TX_EMPTY   = 2;
  localparam int ST_CARRIER    = 3;
  localparam int ST_SYNC_HUNT  = 4;
  localparam int ST_CTS        = 5;

  // Command register bits (write one to act)
  localparam int CMD_RESET_EXT = 0;
  localparam int CMD_EOI       = 1;
  localparam int CMD_RESET     = 2;

  // Event input bits (same-clock logic)
  localparam int EV_PARITY  = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_FRAMING = 2;
  localparam int EV_EOF     = 3;

  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] FLAG_PATTERN = 8'h7e;
  localparam logic [7:0] ALL_ONES     = 8'hff;

  // Vector cause codes (low two bits), channel in bit 2
  localparam logic [1:0] CAUSE_TX   = 2'h0;
  localparam logic [1:0] CAUSE_EXT  = 2'h1;
  localparam logic [1:0] CAUSE_RX   = 2'h2;
  localparam logic [1:0] CAUSE_SPEC = 2'h3;
  localparam logic [2:0] VAR_NONE   = 3'h7;

  // Link-side transmit shifter states
  typedef enum logic [1:0] {MPC_TX_IDLE, MPC_TX_DATA, MPC_TX_CRC}
    mpc_tx_state_t;
endpackage

// ---- rtl/mpc_channel.sv ----
`timescale 1ns/100ps
// Functional notes
// - Parity, overrun, framing, end-of-frame are special
// - Status-modifies-vector chooses variable or fixed vector
// - Vector register driven during interrupt acknowledge
// - Receiver enable bit starts the receiver
// - Sync load inhibit blocks sync characters
// - Address search in SDLC mode accepts ones or programmed address
// - Receive CRC enable starts/pauses, never resets
// - Hunt after init and on hunt write
// - Auto enable lets CD/CTS gate receiver/transmitter
// - Receive length code selects 5,7,6,8 bits
// - Parity even/odd, also sent for eight bits
// - Stop bits and sync mode encodings
// - Clock mode ratio 1,16,32,64
// - Request-to-send bit drives RTS low
// - CRC select: CRC-16 or CCITT; the bit is stored but no output carries it
// - Transmitter disable marks after character ends
// - Send break forces transmit data low
// - Transmit length codes, code zero sends five bits
// - Sync registers hold sync, address, flag
// - In-service sets on acknowledge, clears on END_OF_INTERRUPT_COMMAND
// - Character available and transmit empty status
// - CD change latches carrier status
// - Sync input edges set/clear sync-hunt status in async modes
module mpc_channel
  import mpc_pkg::*;
(
  input  wire logic       ref_clk_in,       // System clock
  input  wire logic       rst_b_in,         // Async reset, low
  input  wire logic [3:0] addr_in,          // Register index
  input  wire logic [7:0] wdata_in,         // Write data
  input  wire logic       wr_in,            // Write strobe
  input  wire logic       rd_in,            // Read strobe
  output logic      [7:0] rdata_out,        // Read data
  input  wire logic       interrupt_acknowledge_in,          // Acknowledge pulse, low
  output logic      [7:0] ack_data_out,     // Vector on acknowledge
  output logic            ack_data_oe_b_out, // Low while driving bus
  input  wire logic [3:0] rx_event_in,      // Receive error events
  input  wire logic       rx_fifo_ne_in,    // Receive FIFO not empty
  input  wire logic       int_pend_in,      // Internal interrupt pending
  input  wire logic [2:0] int_cause_in,     // Highest pending cause
  input  wire logic       sa_vector_in,     // Status modifies vector
  input  wire logic       tx_load_in,       // Transmit buffer load
  input  wire logic [7:0] tx_byte_in,       // Byte to send
  input  wire logic       rx_sync_char_in,  // Received char is sync
  input  wire logic [7:0] rx_addr_in,       // Received frame address
  input  wire logic       cd_b_in,          // Carrier detect pin
  input  wire logic       cts_b_in,         // Clear to send pin
  input  wire logic       sync_detect_input_in, // Sync detect pin
  input  wire logic       tx_bit_clk_in,    // Transmit bit clock pin
  output logic            txd_out,          // Transmit data
  output logic            rts_b_out,        // Request to send, low
  output logic            rx_run_out,       // Receiver running
  output logic            rx_hunt_out,      // Receiver hunting
  output logic            rx_load_ok_out,   // Char may enter FIFO
  output logic            frame_accept_out, // Frame address accepted
  output logic            crc_run_out,      // CRC accumulation on
  output logic            special_out,      // Special receive pulse
  output logic            ext_event_out,    // External status pulse
  output logic      [3:0] rx_bits_out,      // Data bits per char
  output logic      [6:0] clk_ratio_out     // Bit clock ratio
);

  typedef struct packed {
    logic [7:0]    vector;
    logic [7:0]    rx_ctrl;
    logic [7:0]    frame_ctrl;
    logic [7:0]    tx_ctrl;
    logic [7:0]    sync_low;
    logic [7:0]    sync_high;
    logic [7:0]    rdata;
    logic [7:0]    ack_data;
    logic          ack_oe_b;
    logic [2:0]    cd_sync;
    logic [2:0]    cts_sync;
    logic [2:0]    sd_sync;
    logic [2:0]    tck_sync;
    logic          cd_lvl;
    logic          cts_lvl;
    logic          sd_lvl;
    logic [2:0]    interrupt_acknowledge_sync;
    logic [1:0]    interrupt_acknowledge_cnt;
    logic          cd_stat;
    logic          cts_stat;
    logic          sh_stat;
    logic          ext_latched;
    logic          in_service;
    logic          tx_empty;
    logic          hunt;
    logic          special;
    logic          ext_event;
    mpc_tx_state_t tx_state;
    logic [8:0]    tx_shift;
    logic [3:0]    tx_left;
    logic          txd;
  } mpc_state_t;

  mpc_state_t st;
  mpc_state_t nx;

  // Receive length decode, shared by receive and transmit
  function automatic logic [3:0] len_bits(input logic [1:0] code);
    case (code)
      2'h0:    len_bits = 4'h5;
      2'h1:    len_bits = 4'h7;
      2'h2:    len_bits = 4'h6;
      default: len_bits = 4'h8;
    endcase
  endfunction

  // Filtered pin level; a change counts once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic held);
    settle = (s[2] == s[1]) ? s[2] : held;
  endfunction

  logic [1:0] stop_code;
  logic [1:0] sync_mode;
  logic       is_sdlc;
  logic       cd_now;
  logic       cts_now;
  logic       sd_now;
  logic       tck_rise;
  logic       par_bit;
  logic [3:0] tx_len;
  logic       wr_cmd;
  logic       par_en;
  logic [7:0] tx_data;
  logic [8:0] tx_frame;
  logic       interrupt_acknowledge_fall;

  // Stable levels: second and third stage agree
  assign stop_code = st.frame_ctrl[FC_STOP_LO +: 2];
  assign sync_mode = st.frame_ctrl[FC_SYNC_LO +: 2];
  assign is_sdlc   = (stop_code == 2'h0) && (sync_mode == 2'h2);
  assign cd_now    = settle(st.cd_sync, st.cd_lvl);
  assign cts_now   = settle(st.cts_sync, st.cts_lvl);
  assign sd_now    = settle(st.sd_sync, st.sd_lvl);
  assign tck_rise  = st.tck_sync[1] & ~st.tck_sync[2];
  assign tx_len    = (st.tx_ctrl[TC_LEN_LO +: 2] == 2'h0) ? 4'h5 :
                     len_bits(st.tx_ctrl[TC_LEN_LO +: 2]);
  assign wr_cmd    = wr_in && (addr_in == ADDR_CMD);
  assign interrupt_acknowledge_fall = (st.interrupt_acknowledge_sync[2:1] == 2'b10);
  // Unused upper bits masked so they cannot leak into parity
  assign par_en    = st.frame_ctrl[FC_PAR_EN];
  assign tx_data   = tx_byte_in & ~(8'hff << tx_len);
  // Parity over the sent bits; even sense when the bit is one
  assign par_bit   = ^tx_data ^ ~st.frame_ctrl[FC_PAR_EVEN];
  // Data, then parity right after the last data bit, then marking
  assign tx_frame  = {1'b0, tx_data} |
                     ({8'h00, par_en & par_bit} << tx_len) |
                     (9'h1ff << (tx_len + {3'h0, par_en}));

  always_comb
  begin
    nx = st;
    nx.special   = |rx_event_in;
    nx.ext_event = 1'b0;
    nx.cd_sync   = {st.cd_sync[1:0], cd_b_in};
    nx.cts_sync  = {st.cts_sync[1:0], cts_b_in};
    nx.sd_sync   = {st.sd_sync[1:0], sync_detect_input_in};
    nx.tck_sync  = {st.tck_sync[1:0], tx_bit_clk_in};
    nx.interrupt_acknowledge_sync = {st.interrupt_acknowledge_sync[1:0], interrupt_acknowledge_in};
    nx.cd_lvl    = cd_now;
    nx.cts_lvl   = cts_now;
    nx.sd_lvl    = sd_now;

    // Register writes
    if (wr_in)
    begin
      case (addr_in)
        ADDR_VECTOR:     nx.vector     = wdata_in;
        ADDR_RX_CTRL:    nx.rx_ctrl    = wdata_in;
        ADDR_FRAME_CTRL: nx.frame_ctrl = wdata_in;
        ADDR_TX_CTRL:    nx.tx_ctrl    = wdata_in;
        ADDR_SYNC_LOW:   nx.sync_low   = wdata_in;
        ADDR_SYNC_HIGH:  nx.sync_high  = wdata_in;
        default:         nx.rx_ctrl    = st.rx_ctrl;
      endcase
    end
    // Hunt bit is an action: re-enter hunt, not stored
    if (wr_in && addr_in == ADDR_RX_CTRL && wdata_in[RC_HUNT])
      nx.hunt = 1'b1;
    nx.rx_ctrl[RC_HUNT] = 1'b0;

    // External status: latched until reset-ext or channel reset command
    if (!st.ext_latched)
    begin
      if (cd_now != st.cd_stat)
      begin
        nx.cd_stat     = cd_now;
        nx.ext_latched = 1'b1;
        nx.ext_event   = 1'b1;
      end
      if (cts_now != st.cts_stat)
      begin
        nx.cts_stat    = cts_now;
        nx.ext_latched = 1'b1;
        nx.ext_event   = 1'b1;
      end
      if (stop_code != 2'h0 && sd_now == st.sh_stat)
      begin
        nx.sh_stat     = ~sd_now;
        nx.ext_latched = 1'b1;
        nx.ext_event   = 1'b1;
      end
    end
    if (wr_cmd && wdata_in[CMD_RESET_EXT])
    begin
      nx.ext_latched = 1'b0;
      nx.cd_stat     = cd_now;
      nx.cts_stat    = cts_now;
      nx.sh_stat     = ~sd_now;
    end
    // Sync-hunt in sync modes follows the hunt state
    if (stop_code == 2'h0)
      nx.sh_stat = nx.hunt;

    // END_OF_INTERRUPT_COMMAND first, so a pulse in the same cycle still sets the flag
    if (wr_cmd && wdata_in[CMD_EOI])
      nx.in_service = 1'b0;
    // Pulses counted in pairs; a lone stray pulse shifts the pairing
    if (interrupt_acknowledge_fall)
    begin
      nx.interrupt_acknowledge_cnt = (st.interrupt_acknowledge_cnt == 2'h1) ? 2'h0 : st.interrupt_acknowledge_cnt + 2'h1;
      if (st.interrupt_acknowledge_cnt == 2'h1 && int_pend_in)
        nx.in_service = 1'b1;
    end
    // Drive vector once both settled stages see the pulse low
    nx.ack_oe_b = st.interrupt_acknowledge_sync[1] | st.interrupt_acknowledge_sync[2];
    nx.ack_data = sa_vector_in ?
      {st.vector[7:5], int_pend_in ? int_cause_in : VAR_NONE,
       st.vector[1:0]} : st.vector;

    // Transmit buffer and shifter on sampled bit clock
    if (tx_load_in)
      nx.tx_empty = 1'b0;
    case (st.tx_state)
      MPC_TX_IDLE:
      begin
        nx.txd = 1'b1;
        if (!st.tx_empty && st.tx_ctrl[TC_TX_EN] &&
            (!st.rx_ctrl[RC_AUTO] || !cts_now) && tck_rise)
        begin
          nx.tx_shift = tx_frame;
          nx.tx_left  = tx_len + {3'h0, par_en};
          nx.tx_state = MPC_TX_DATA;
          nx.tx_empty = 1'b1;
          nx.txd      = 1'b0;
        end
      end
      MPC_TX_DATA:
        if (tck_rise)
        begin
          // Whole character completes once started, unless a channel reset command
          nx.txd      = st.tx_shift[0];
          nx.tx_shift = {1'b1, st.tx_shift[8:1]};
          nx.tx_left  = st.tx_left - 4'h1;
          // One more bit time, so the last bit is not cut short
          if (st.tx_left == 4'h0)
          begin
            nx.txd      = 1'b1;
            nx.tx_left  = 4'h0;
            nx.tx_state = MPC_TX_IDLE;
          end
        end
      default: nx.tx_state = MPC_TX_IDLE;
    endcase

    // Register read, data valid next cycle
    nx.rdata = RESET_BYTE;
    if (rd_in)
    begin
      case (addr_in)
        ADDR_STATUS: nx.rdata = {2'h0, st.cts_stat, st.sh_stat,
                                 st.cd_stat, st.tx_empty,
                                 st.in_service, rx_fifo_ne_in};
        ADDR_VECTOR: nx.rdata = nx.ack_data;
        default:     nx.rdata = RESET_BYTE;
      endcase
    end

    // Channel reset command restores defaults
    if (wr_cmd && wdata_in[CMD_RESET])
    begin
      nx.rx_ctrl    = RESET_BYTE;
      nx.frame_ctrl = RESET_BYTE;
      nx.tx_ctrl    = RESET_BYTE;
      nx.tx_empty   = 1'b1;
      nx.hunt       = 1'b1;
      nx.in_service = 1'b0;
      nx.ext_latched = 1'b0;
      nx.tx_state   = MPC_TX_IDLE;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st            <= '0;
      st.tx_empty   <= 1'b1;
      st.hunt       <= 1'b1;
      st.txd        <= 1'b1;
      st.ack_oe_b   <= 1'b1;
      st.cd_sync    <= 3'h7;
      st.cts_sync   <= 3'h7;
      st.sd_sync    <= 3'h7;
      st.interrupt_acknowledge_sync  <= 3'h7;
      st.cd_lvl     <= 1'b1;
      st.cts_lvl    <= 1'b1;
      st.sd_lvl     <= 1'b1;
      st.cd_stat    <= 1'b1;
      st.cts_stat   <= 1'b1;
      st.sync_high  <= FLAG_PATTERN;
    end
    else
      st <= nx;
  end

  // Outputs; hunt stays set once entered, nothing here clears it
  assign rdata_out         = st.rdata;
  assign ack_data_out      = st.ack_data;
  assign ack_data_oe_b_out = st.ack_oe_b;
  assign txd_out           = st.tx_ctrl[TC_BREAK] ? 1'b0 : st.txd;
  assign rts_b_out         = ~st.tx_ctrl[TC_RTS];
  assign rx_run_out        = st.rx_ctrl[RC_ENABLE] &&
                             (!st.rx_ctrl[RC_AUTO] || !cd_now);
  assign rx_hunt_out       = st.hunt;
  assign rx_load_ok_out    = !(rx_sync_char_in &&
                               st.rx_ctrl[RC_SYNC_INH]);
  assign frame_accept_out  = !(is_sdlc && st.rx_ctrl[RC_ADDR_SRCH]) ||
                             rx_addr_in == ALL_ONES ||
                             rx_addr_in == st.sync_low;
  assign crc_run_out       = st.rx_ctrl[RC_CRC_EN];
  assign special_out       = st.special;
  assign ext_event_out     = st.ext_event;
  assign rx_bits_out       = len_bits(st.rx_ctrl[RC_LEN_LO +: 2]);
  // CRC16 select and the sync_high register drive no output port
  assign clk_ratio_out     = (st.frame_ctrl[FC_CLK_LO +: 2] == 2'h0) ?
                             7'h01 : (7'h08 <<
                             st.frame_ctrl[FC_CLK_LO +: 2]);

endmodule // mpc_channel

// ---- verif/mpc_channel_sva.sv ----
`timescale 1ns/100ps
module mpc_channel_sva
  import mpc_pkg::*;
(
  input wire logic       ref_clk_in,        // System clock
  input wire logic       rst_b_in,          // Async reset, low
  input wire logic [3:0] addr_in,           // Register index
  input wire logic [7:0] wdata_in,          // Write data
  input wire logic       wr_in,             // Write strobe
  input wire logic       rd_in,             // Read strobe
  input wire logic [7:0] rdata_out,         // Read data
  input wire logic       interrupt_acknowledge_in,           // Acknowledge, low
  input wire logic       ack_data_oe_b_out, // Bus enable, low
  input wire logic [3:0] rx_event_in,       // Receive events
  input wire logic       txd_out,           // Transmit data
  input wire logic       rts_b_out,         // Request to send
  input wire logic       crc_run_out,       // CRC running
  input wire logic       special_out,       // Special pulse
  input wire logic [3:0] rx_bits_out,       // Bits per char
  input wire logic [6:0] clk_ratio_out      // Clock ratio
);
  // One domain, so clock and reset are given once
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  rts_level_a: assert property (wr_in && addr_in == ADDR_TX_CTRL |=>
    rts_b_out == !$past(wdata_in[TC_RTS])) else $error("rts level wrong");
  break_low_a: assert property (wr_in && addr_in == ADDR_TX_CTRL
    && wdata_in[TC_BREAK] |=> ##[0:2] !txd_out) else $error("break lost");
  special_pulse_a: assert property (special_out ==
    (|$past(rx_event_in))) else $error("special pulse wrong");
  read_idle_a: assert property (!$past(rd_in) |->
    rdata_out == 8'h00) else $error("read data outside slot");
  unmapped_zero_a: assert property (rd_in && addr_in > ADDR_CMD |=>
    rdata_out == 8'h00) else $error("unmapped read not zero");
  rx_len_a: assert property (wr_in && addr_in == ADDR_RX_CTRL |=>
    rx_bits_out == ($past(wdata_in[7:6]) == 2'h0 ? 4'h5 :
    $past(wdata_in[7:6]) == 2'h1 ? 4'h7 :
    $past(wdata_in[7:6]) == 2'h2 ? 4'h6 : 4'h8)) else $error("rx length");
  clk_mode_a: assert property (wr_in && addr_in == ADDR_FRAME_CTRL |=>
    clk_ratio_out == ($past(wdata_in[7:6]) == 2'h0 ? 7'h01 :
    $past(wdata_in[7:6]) == 2'h1 ? 7'h10 :
    $past(wdata_in[7:6]) == 2'h2 ? 7'h20 : 7'h40)) else $error("clock ratio");
  crc_run_a: assert property (wr_in && addr_in == ADDR_RX_CTRL |=>
    crc_run_out == $past(wdata_in[RC_CRC_EN])) else $error("crc enable");
  ack_idle_a: assert property (interrupt_acknowledge_in [*4] |-> ack_data_oe_b_out)
    else $error("bus driven without acknowledge");
endmodule // mpc_channel_sva

bind mpc_channel mpc_channel_sva u_sva (.ref_clk_in, .rst_b_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .interrupt_acknowledge_in, .ack_data_oe_b_out,
  .rx_event_in, .txd_out, .rts_b_out, .crc_run_out, .special_out,
  .rx_bits_out, .clk_ratio_out);

// ---- verif/mpc_ack_host.sv ----
`timescale 1ns/100ps
module mpc_ack_host
(
  input  wire logic       clk_in,     // System clock
  input  wire logic       start_in,   // Run one acknowledge cycle
  input  wire logic [7:0] bus_in,     // Vector from the channel
  input  wire logic       oe_b_in,    // Channel drives bus, low
  output logic            interrupt_acknowledge_b_out, // Acknowledge pulse, low
  output logic      [7:0] vec_out,    // Vector taken on 2nd pulse
  output logic            done_out    // Cycle finished
);
  initial
  begin
    interrupt_acknowledge_b_out = 1'b1;
    vec_out = 8'h00;
    done_out = 1'b0;
  end

  // Two pulses; an undriven bus reads as the inverse, never a match
  always
  begin
    @(posedge clk_in);
    if (start_in)
    begin
      repeat (2)
      begin
        interrupt_acknowledge_b_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        vec_out <= oe_b_in ? ~bus_in : bus_in;
        interrupt_acknowledge_b_out <= 1'b1;
        repeat (4) @(posedge clk_in);
      end
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
    end
  end
endmodule // mpc_ack_host

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import mpc_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d, e;} mpc_row_t;
  logic       ref_clk_in, rst_b_in, wr_in, rd_in, interrupt_acknowledge_in, rx_fifo_ne_in;
  logic       int_pend_in, sa_vector_in, tx_load_in, rx_sync_char_in;
  logic       cd_b_in, cts_b_in, sync_detect_input_in, tx_bit_clk_in;
  logic       start, done, ack_data_oe_b_out, txd_out, rts_b_out;
  logic       rx_run_out, rx_hunt_out, rx_load_ok_out, frame_accept_out;
  logic       crc_run_out, special_out, ext_event_out;
  logic [2:0] int_cause_in;
  logic [3:0] addr_in, rx_event_in, rx_bits_out;
  logic [6:0] clk_ratio_out;
  logic [7:0] wdata_in, tx_byte_in, rx_addr_in, rdata_out, ack_data_out;
  logic [7:0] got, vec;
  logic [10:0] tx_bits;
  int         err_count, comparisons, i;
  // Ordinary cases: write, then the port or readback it should set
  mpc_row_t rows [11] = '{
    '{ADDR_RX_CTRL, 8'h00, 8'h05}, '{ADDR_RX_CTRL, 8'h48, 8'h07},
    '{ADDR_RX_CTRL, 8'h80, 8'h06}, '{ADDR_RX_CTRL, 8'hc0, 8'h08},
    '{ADDR_FRAME_CTRL, 8'h00, 8'h01}, '{ADDR_FRAME_CTRL, 8'h44, 8'h10},
    '{ADDR_FRAME_CTRL, 8'h80, 8'h20}, '{ADDR_FRAME_CTRL, 8'hc0, 8'h40},
    '{ADDR_TX_CTRL, 8'h02, 8'h00}, '{ADDR_TX_CTRL, 8'h00, 8'h01},
    '{ADDR_VECTOR, 8'h5a, 8'h5a}};

  mpc_channel uut (.ref_clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .interrupt_acknowledge_in, .ack_data_out, .ack_data_oe_b_out,
    .rx_event_in, .rx_fifo_ne_in, .int_pend_in, .int_cause_in,
    .sa_vector_in, .tx_load_in, .tx_byte_in, .rx_sync_char_in, .rx_addr_in,
    .cd_b_in, .cts_b_in, .sync_detect_input_in, .tx_bit_clk_in, .txd_out,
    .rts_b_out, .rx_run_out, .rx_hunt_out, .rx_load_ok_out,
    .frame_accept_out, .crc_run_out, .special_out, .ext_event_out,
    .rx_bits_out, .clk_ratio_out);
  mpc_ack_host host (.clk_in(ref_clk_in), .start_in(start),
    .bus_in(ack_data_out), .oe_b_in(ack_data_oe_b_out),
    .interrupt_acknowledge_b_out(interrupt_acknowledge_in), .vec_out(vec), .done_out(done));

  // System clock, and a link clock unrelated in phase
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    tx_bit_clk_in = 1'b0;
    #5;
    forever #16 tx_bit_clk_in = ~tx_bit_clk_in;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    got = rdata_out;
  endtask
  // Bounded wait for a one-cycle pulse; a miss ends the run
  task automatic wait_pulse(input logic ext);
    for (i = 0; i < 60 && !(ext ? ext_event_out : done); i++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    if (i == 60)
    begin
      chk("pulse wait", 8'h01, 8'h00);
      wrap_up();
    end
  endtask
  task automatic ack;
    @(posedge ref_clk_in);
    start <= 1'b1;
    @(posedge ref_clk_in);
    start <= 1'b0;
    wait_pulse(1'b0);
  endtask

  initial
  begin
    {rst_b_in, wr_in, rd_in, rx_fifo_ne_in, int_pend_in, start} = '0;
    {sa_vector_in, tx_load_in, rx_sync_char_in, addr_in} = '0;
    {rx_event_in, int_cause_in, wdata_in, rx_addr_in} = '0;
    {cd_b_in, cts_b_in, sync_detect_input_in} = 3'h7;
    tx_byte_in = 8'h55;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk("rts_b reset", 8'h01, {7'h00, rts_b_out});
    chk("txd reset", 8'h01, {7'h00, txd_out});
    chk("hunt reset", 8'h01, {7'h00, rx_hunt_out});
    rst_b_in <= 1'b1;
    rd(ADDR_STATUS);
    chk("status reset", 8'h0c, got & 8'h0d);
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      @(posedge ref_clk_in);
      #1;
      got = rows[k].a == ADDR_RX_CTRL ? {4'h0, rx_bits_out} :
        rows[k].a == ADDR_FRAME_CTRL ? {1'b0, clk_ratio_out} :
        {7'h00, rts_b_out};
      if (rows[k].a == ADDR_VECTOR)
        rd(ADDR_VECTOR);
      chk("row", rows[k].e, got);
    end
    rd(4'hf);
    chk("unmapped", 8'h00, got);
    // Each error kind alone must raise the special pulse
    for (int b = 0; b < 4; b++)
    begin
      @(posedge ref_clk_in);
      rx_event_in <= 4'h1 << b;
      @(posedge ref_clk_in);
      rx_event_in <= 4'h0;
      #1;
      chk("special", 8'h01, {7'h00, special_out});
    end
    wr(ADDR_TX_CTRL, 8'h10);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("txd break", 8'h00, {7'h00, txd_out});
    wr(ADDR_TX_CTRL, 8'h00);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("txd mark", 8'h01, {7'h00, txd_out});
    @(posedge ref_clk_in);
    rx_fifo_ne_in <= 1'b1;
    tx_load_in <= 1'b1;
    @(posedge ref_clk_in);
    tx_load_in <= 1'b0;
    rd(ADDR_STATUS);
    chk("status loaded", 8'h09, got & 8'h0d);
    // A row write latched a sync change; release it before watching CD
    wr(ADDR_CMD, 8'h01);
    cd_b_in <= 1'b0;
    wait_pulse(1'b1);
    rd(ADDR_STATUS);
    chk("carrier", 8'h00, got & 8'h08);
    wr(ADDR_VECTOR, 8'ha0);
    int_pend_in <= 1'b1;
    int_cause_in <= 3'h6;
    ack();
    chk("fixed vector", 8'ha0, vec);
    rd(ADDR_STATUS);
    chk("in service", 8'h02, got & 8'h02);
    wr(ADDR_CMD, 8'h02);
    rd(ADDR_STATUS);
    chk("in service cleared", 8'h00, got & 8'h02);
    sa_vector_in <= 1'b1;
    ack();
    // Cause code sits in vector bits four to two
    chk("variable vector", 8'hb8, vec);
    rd(ADDR_STATUS);
    chk("in service again", 8'h02, got & 8'h02);
    // Auto enable: carrier low lets the receiver run, high stops it
    wr(ADDR_RX_CTRL, 8'h21);
    @(posedge ref_clk_in);
    #1;
    chk("rx run", 8'h01, {7'h00, rx_run_out});
    cd_b_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    #1;
    chk("rx gated", 8'h00, {7'h00, rx_run_out});
    wr(ADDR_RX_CTRL, 8'h02);
    rx_sync_char_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    chk("sync load", 8'h00, {7'h00, rx_load_ok_out});
    rx_sync_char_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk("data load", 8'h01, {7'h00, rx_load_ok_out});
    // Address search in flag mode: own address or all ones only
    wr(ADDR_FRAME_CTRL, 8'h20);
    wr(ADDR_SYNC_LOW, 8'h3c);
    wr(ADDR_RX_CTRL, 8'h04);
    for (int n = 0; n < 3; n++)
    begin
      rx_addr_in <= n == 0 ? 8'h3c : n == 1 ? 8'h12 : ALL_ONES;
      @(posedge ref_clk_in);
      #1;
      chk("frame accept", {7'h00, n != 1}, {7'h00, frame_accept_out});
    end
    // One character: start bit, eight data bits, even parity, mark
    tx_byte_in <= 8'h57;
    wr(ADDR_FRAME_CTRL, 8'h03);
    wr(ADDR_TX_CTRL, 8'h68);
    for (i = 0; i < 40 && txd_out; i++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    if (i == 40)
    begin
      chk("tx start", 8'h00, 8'h01);
      wrap_up();
    end
    // Sample each bit in the middle of its eight-cycle bit time
    repeat (4) @(posedge ref_clk_in);
    for (int n = 0; n < 11; n++)
    begin
      #1;
      tx_bits[n] = txd_out;
      repeat (8) @(posedge ref_clk_in);
    end
    chk("tx data", 8'h57, tx_bits[8:1]);
    chk("tx framing", 8'h06, {5'h00, tx_bits[10:9], tx_bits[0]});
    wrap_up();
  end
endmodule // testbench
